// >>> hdl/pattern_gen_pkg.sv
// Constants shared by the output test pattern generator files.
package pattern_gen_pkg;

    // Register indices; the bus byte address is four times the index.
    localparam logic [7:0] IDX_USER_ONE_LO = 8'h33;
    localparam logic [7:0] IDX_USER_ONE_HI = 8'h34;
    localparam logic [7:0] IDX_USER_TWO_LO = 8'h35;
    localparam logic [7:0] IDX_USER_TWO_HI = 8'h36;
    localparam logic [7:0] IDX_SOURCE_SEL  = 8'h37;
    localparam logic [7:0] IDX_RESTART_CTL = 8'h3a;
    localparam logic [7:0] IDX_STATUS      = 8'h3c;

    // Field positions.
    localparam int SEL_LSB     = 0;
    localparam int PERMIT_BIT  = 0;
    localparam int PULSE_BIT   = 1;
    localparam int STAT_PHASE  = 0;
    localparam int STAT_RAMP   = 16;

    // Values after reset.
    localparam logic [15:0] USER_WORD_RST = 16'h0000;
    localparam logic [3:0]  SEL_RST       = 4'h0;

    // Pattern source selector codes.
    localparam logic [3:0] SEL_NORMAL = 4'h0;
    localparam logic [3:0] SEL_ZEROS  = 4'h1;
    localparam logic [3:0] SEL_ONES   = 4'h2;
    localparam logic [3:0] SEL_TOGGLE = 4'h3;
    localparam logic [3:0] SEL_RAMP   = 4'h4;
    localparam logic [3:0] SEL_SINGLE = 4'h6;
    localparam logic [3:0] SEL_DOUBLE = 4'h7;
    localparam logic [3:0] SEL_DESKEW = 4'h8;

    // Highest ramp code before it wraps to zero.
    localparam int RAMP_MAX = 16384;

    // Depth of the output FIFO.
    localparam int FIFO_DEPTH = 32;

endpackage

// >>> hdl/sample_stream_if.sv
// Valid/ready sample stream into and out of the generator's FIFO.
`timescale 1ns/1ps
interface sample_stream_if #(parameter int W = 16);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// >>> hdl/sample_fifo.sv
// Synchronous valid/ready FIFO for output samples.
`timescale 1ns/1ps
module sample_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // Filling side
    sample_stream_if.snk    fill,
    // Draining side
    sample_stream_if.src    drain
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power-of-two depth.
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : gen_param_check
        $error("sample_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } fifo_s;

    fifo_s st_q;
    fifo_s st_d;
    logic  full;
    logic  empty;

    assign empty       = (st_q.wp == st_q.rp);
    assign full        = (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]) && !empty;
    assign fill.ready  = !full;
    assign drain.valid = !empty;
    assign drain.data  = st_q.mem[st_q.rp[AW-1:0]];

    always_comb begin
        st_d = st_q;
        if (fill.valid && !full) begin
            st_d.mem[st_q.wp[AW-1:0]] = fill.data;
            st_d.wp = st_q.wp + 1'b1;
        end
        if (drain.ready && !empty) begin
            st_d.rp = st_q.rp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

// >>> hdl/pattern_gen.sv
// Output test pattern generator with AHB-Lite registers and output FIFO.
`timescale 1ns/1ps
module pattern_gen
    import pattern_gen_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          reset,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    // Converter samples
    input  wire logic [W-1:0]  sample_in,
    input  wire logic          sample_valid,
    output logic               sample_ready,
    // Output samples toward the serial path
    output logic [W-1:0]       out_data,
    output logic               out_valid,
    input  wire logic          out_ready
);
    import pattern_gen_pkg::*;

    // Narrower samples could not hold the ramp's top code.
    if (W < 16 || W > 32 || (W % 2) != 0) begin : gen_w_check
        $error("pattern_gen: W must be even and from 16 to 32");
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [15:0]  user_one;
        logic [15:0]  user_two;
        logic [3:0]   sel;
        logic         pulse;
        logic         permit;
        logic [W-1:0] ramp;
        logic         phase;
        logic         wr_pend;
        logic [7:0]   wr_idx;
        logic [31:0]  rdata;
    } state_s;

    state_s st_q;
    state_s st_d;

    sample_stream_if #(.W(W)) gen_s ();
    sample_stream_if #(.W(W)) out_s ();

    logic         accept;
    logic         mapped;
    logic [7:0]   a_idx;
    logic         is_pattern;
    logic         push;
    logic         restart;
    logic [W-1:0] gen_data;

    localparam logic [W-1:0] RAMP_TOP = W'(RAMP_MAX);

    // Register file read view of a given state.
    function automatic logic [31:0] read_reg(input state_s s,
                                             input logic [7:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (idx)
            IDX_USER_ONE_LO: v[7:0] = s.user_one[7:0];
            IDX_USER_ONE_HI: v[7:0] = s.user_one[15:8];
            IDX_USER_TWO_LO: v[7:0] = s.user_two[7:0];
            IDX_USER_TWO_HI: v[7:0] = s.user_two[15:8];
            IDX_SOURCE_SEL:  v[SEL_LSB +: 4] = s.sel;
            IDX_RESTART_CTL: begin
                v[PULSE_BIT]  = s.pulse;
                v[PERMIT_BIT] = s.permit;
            end
            IDX_STATUS: begin
                v[STAT_RAMP +: 16] = s.ramp[15:0];
                v[STAT_PHASE]      = s.phase;
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // The slave never stalls, so every transfer completes in one data phase.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_q.rdata;
    assign accept    = hsel && htrans[1] && hready;
    assign mapped    = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
    assign a_idx     = mapped ? haddr[9:2] : 8'hff;

    assign restart = st_q.wr_pend && (st_q.wr_idx == IDX_RESTART_CTL)
                     && hwdata[PULSE_BIT] && !st_q.pulse && st_q.permit;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        gen_data = sample_in;
        unique case (st_q.sel)
            SEL_ZEROS:  gen_data = '0;
            SEL_ONES:   gen_data = '1;
            SEL_TOGGLE: gen_data = st_q.phase ? {(W/2){2'b01}}
                                              : {(W/2){2'b10}};
            SEL_RAMP:   gen_data = st_q.ramp;
            SEL_SINGLE: gen_data = W'(st_q.user_one);
            SEL_DOUBLE: gen_data = st_q.phase ? W'(st_q.user_two)
                                              : W'(st_q.user_one);
            SEL_DESKEW: gen_data = '1;
            default:    gen_data = sample_in;
        endcase
    end

    assign is_pattern = (st_q.sel inside {SEL_ZEROS, SEL_ONES, SEL_TOGGLE,
                         SEL_RAMP, SEL_SINGLE, SEL_DOUBLE, SEL_DESKEW});

    // Pattern samples replace converter data, which is then consumed unused.
    assign gen_s.data    = gen_data;
    assign gen_s.valid   = is_pattern ? 1'b1 : sample_valid;
    assign sample_ready  = is_pattern ? 1'b1 : gen_s.ready;
    assign push          = gen_s.valid && gen_s.ready;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.wr_pend = accept && hwrite;
        st_d.wr_idx  = a_idx;
        if (st_q.wr_pend) begin
            unique case (st_q.wr_idx)
                IDX_USER_ONE_LO: st_d.user_one[7:0]  = hwdata[7:0];
                IDX_USER_ONE_HI: st_d.user_one[15:8] = hwdata[7:0];
                IDX_USER_TWO_LO: st_d.user_two[7:0]  = hwdata[7:0];
                IDX_USER_TWO_HI: st_d.user_two[15:8] = hwdata[7:0];
                // only the low selector bits are kept
                IDX_SOURCE_SEL:  st_d.sel = hwdata[SEL_LSB +: 4];
                IDX_RESTART_CTL: begin
                    st_d.pulse  = hwdata[PULSE_BIT];
                    st_d.permit = hwdata[PERMIT_BIT];
                end
                default: st_d.wr_idx = a_idx;
            endcase
        end
        if (push && is_pattern) begin
            if (st_q.sel == SEL_RAMP) begin
                st_d.ramp = (st_q.ramp == RAMP_TOP) ? '0
                                                    : st_q.ramp + 1'b1;
            end
            if (st_q.sel == SEL_TOGGLE || st_q.sel == SEL_DOUBLE) begin
                st_d.phase = !st_q.phase;
            end
        end
        if (restart) begin
            st_d.ramp  = '0;
            st_d.phase = 1'b0;
        end
        // Reading the next state forwards a write still in its data phase.
        if (accept && !hwrite) begin
            st_d.rdata = read_reg(st_d, a_idx);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q          <= '0;
            st_q.user_one <= USER_WORD_RST;
            st_q.user_two <= USER_WORD_RST;
            st_q.sel      <= SEL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sample_fifo #(
        .W     (W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .reset   (reset),
        .fill    (gen_s),
        .drain   (out_s)
    );

    assign out_data    = out_s.data;
    assign out_valid   = out_s.valid;
    assign out_s.ready = out_ready;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence tog_push;
        push && st_q.sel == SEL_TOGGLE && !restart;
    endsequence
    sequence ramp_push;
        push && st_q.sel == SEL_RAMP && !restart;
    endsequence
    sequence dbl_push;
        push && st_q.sel == SEL_DOUBLE && !restart;
    endsequence
    // A write in its data phase to the restart control register.
    sequence ctl_write;
        st_q.wr_pend && st_q.wr_idx == IDX_RESTART_CTL;
    endsequence

    // Pattern checks are taken at the generator side of the FIFO.
    pass_through_a: assert property (
        !is_pattern |-> gen_s.data == sample_in
                        && gen_s.valid == sample_valid)
        else $error("normal mode does not pass converter data");
    zeros_out_a: assert property (
        st_q.sel == SEL_ZEROS |-> gen_s.valid && gen_s.data == '0)
        else $error("zero pattern not all zeros");
    ones_out_a: assert property (
        st_q.sel == SEL_ONES |-> gen_s.valid && gen_s.data == '1)
        else $error("ones pattern not all ones");
    toggle_alt_a: assert property (
        tog_push ##1 (push && st_q.sel == SEL_TOGGLE)
        |-> gen_s.data == ~$past(gen_s.data))
        else $error("toggle pattern did not invert");
    ramp_step_a: assert property (
        ramp_push ##1 (push && st_q.sel == SEL_RAMP)
        |-> gen_s.data == (($past(gen_s.data) == RAMP_TOP) ? '0
                           : $past(gen_s.data) + 1'b1))
        else $error("ramp did not step by one");
    user_single_a: assert property (
        st_q.sel == SEL_SINGLE |-> gen_s.data == W'(st_q.user_one))
        else $error("single pattern wrong word");
    user_double_a: assert property (
        dbl_push ##1 (push && st_q.sel == SEL_DOUBLE)
        |-> $past(gen_s.data) != gen_s.data
            || st_q.user_one == st_q.user_two)
        else $error("double pattern did not alternate");
    deskew_word_a: assert property (
        st_q.sel == SEL_DESKEW |-> gen_s.data == '1)
        else $error("deskew word not all ones");
    restart_start_a: assert property (
        restart |=> st_q.ramp == '0 && !st_q.phase)
        else $error("restart did not clear sequence");
    // Without a stored permit nothing but a push may move the sequence.
    restart_gate_a: assert property (
        !st_q.permit && !push |=> $stable(st_q.ramp) && $stable(st_q.phase))
        else $error("restart fired without permit");
    restart_write_a: assert property (
        ctl_write ##0 (hwdata[PULSE_BIT] && !st_q.pulse && st_q.permit)
        |=> st_q.ramp == '0 && !st_q.phase)
        else $error("restart write did not clear sequence");
    ramp_wrap_a: assert property (
        ramp_push ##0 (st_q.ramp == RAMP_TOP) |=> st_q.ramp == '0)
        else $error("ramp did not wrap to zero");
    stall_freeze_a: assert property (
        is_pattern && !gen_s.ready && !restart
        |=> $stable(st_q.ramp) && $stable(st_q.phase))
        else $error("sequence moved while the FIFO was full");
    undefined_code_a: assert property (
        st_q.sel inside {4'h5, [4'h9:4'hf]}
        |-> gen_s.valid == sample_valid && gen_s.data == sample_in)
        else $error("undefined code is not pass-through");

    // Register side: fields land where they belong and read back.
    select_field_a: assert property (
        st_q.wr_pend && st_q.wr_idx == IDX_SOURCE_SEL
        |=> st_q.sel == $past(hwdata[SEL_LSB +: 4]))
        else $error("selector write not kept");
    select_read_a: assert property (
        accept && !hwrite && a_idx == IDX_SOURCE_SEL && !st_q.wr_pend
        |=> hrdata[31:4] == '0 && hrdata[3:0] == st_q.sel)
        else $error("selector read wrong");
    user_word_a: assert property (
        st_q.wr_pend && st_q.wr_idx == IDX_USER_TWO_HI
        |=> st_q.user_two[15:8] == $past(hwdata[7:0]))
        else $error("user word high byte not kept");

endmodule

// >>> testbench/sink_model.sv
// Downstream sample sink standing at the far end of the output stream.
`timescale 1ns/1ps
module sink_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Sample stream
    input  wire logic [15:0] out_data,
    input  wire logic        out_valid,
    output logic             out_ready,
    // Pace: 0 stalls, 1 always ready, 2 ready every other cycle
    input  wire logic [1:0]  pace
);
    logic [15:0] got[$];
    logic        tick;

    initial begin
        out_ready = 1'b0;
        tick = 1'b0;
    end

    // A word counts only at an edge where both valid and ready are high.
    always @(posedge ref_clk) begin
        if (reset) begin
            out_ready <= 1'b0;
        end else begin
            if (out_valid && out_ready) begin
                got.push_back(out_data);
            end
            tick <= !tick;
            out_ready <= (pace == 2'h1) || (pace == 2'h2 && tick);
        end
    end
endmodule

// >>> testbench/tb.sv
// Self-checking testbench for the output test pattern generator.
`timescale 1ns/1ps
module tb;
    import pattern_gen_pkg::*;

    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic   hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [15:0] sample_in = 16'hC000;
    logic        sample_valid = 1'b0;
    logic        sample_ready;
    logic [15:0] out_data;
    logic        out_valid;
    logic        out_ready;
    logic [1:0]  pace = 2'h1;
    int          fail_count = 0;
    int          n_checks = 0;
    logic [15:0] u1 = 16'h5A3C;
    logic [15:0] u2 = 16'hC3A5;

    assign hready = hreadyout;
    always #25 ref_clk = !ref_clk;

    pattern_gen u_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .sample_in(sample_in), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .out_data(out_data),
        .out_valid(out_valid), .out_ready(out_ready));

    sink_model u_sink (.ref_clk(ref_clk), .reset(reset),
        .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready), .pace(pace));

    // The converter offers a counting sample; it moves on once taken.
    always @(posedge ref_clk) begin
        if (sample_valid && sample_ready) begin
            sample_in <= sample_in + 16'h0001;
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        ahb(1'b1, idx, wd, rd);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx,
                          input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, idx, 32'h0000_0000, rd);
        chk(name, exp, rd);
        chk("hresp_okay", 32'h0, 32'(hresp));
    endtask

    // Reset values, user words and the unmapped hole.
    task automatic test_registers;
        rd_chk("user_one_lo", IDX_USER_ONE_LO, 32'h0000_0000);
        rd_chk("user_two_hi", IDX_USER_TWO_HI, 32'h0000_0000);
        rd_chk("select_rst", IDX_SOURCE_SEL, 32'h0000_0000);
        rd_chk("restart_rst", IDX_RESTART_CTL, 32'h0000_0000);
        wr(8'h10, 32'h0000_00FF);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        wr(IDX_USER_ONE_LO, {24'h0, u1[7:0]});
        wr(IDX_USER_ONE_HI, {24'h0, u1[15:8]});
        wr(IDX_USER_TWO_LO, {24'h0, u2[7:0]});
        wr(IDX_USER_TWO_HI, {24'h0, u2[15:8]});
        rd_chk("user_one_hi", IDX_USER_ONE_HI, {24'h0, u1[15:8]});
        rd_chk("user_two_lo", IDX_USER_TWO_LO, {24'h0, u2[7:0]});
        wr(IDX_SOURCE_SEL, 32'h0000_0005);
        rd_chk("select_rw", IDX_SOURCE_SEL, 32'h0000_0005);
    endtask

    // Old words drain first, so only a later slice of the stream counts.
    task automatic check_mode(input logic [3:0] sel);
        logic [15:0] w[$];
        wr(IDX_SOURCE_SEL, {28'h0, sel});
        repeat (45) @(posedge ref_clk);
        @(negedge ref_clk);
        u_sink.got.delete();
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        w = u_sink.got;
        chk("mode_words", 32'h0000_0001, 32'(w.size() > 8));
        for (int k = 1; k < w.size(); k++) begin
            case (sel)
                SEL_ZEROS: chk("zeros", 32'h0, w[k]);
                SEL_ONES: chk("ones", 32'hFFFF, w[k]);
                SEL_TOGGLE: chk("toggle", {16'h0, ~w[k-1]}, w[k]);
                SEL_RAMP: chk("ramp", w[k-1] + 16'h1, w[k]);
                SEL_SINGLE: chk("single", u1, w[k]);
                SEL_DOUBLE: chk("double", w[k-1] == u1 ? u2 : u1, w[k]);
                SEL_DESKEW: chk("deskew", 32'hFFFF, w[k]);
                default: chk("normal", w[k-1] + 16'h1, w[k]);
            endcase
        end
        if (sel == SEL_TOGGLE) begin
            chk("toggle_set", 1, 32'(w[0] inside {16'hAAAA, 16'h5555}));
        end else if (!(sel inside {[1:4], [6:8]})) begin
            chk("normal_src", 32'h3, w[0][15:14]);
        end
    endtask

    // Fill the FIFO until the converter is refused, then drain slowly.
    task automatic test_fill_drain;
        logic [15:0] w[$];
        pace = 2'h0;
        wr(IDX_SOURCE_SEL, 32'h0000_0000);
        repeat (45) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("refused", 32'h0, sample_ready);
        u_sink.got.delete();
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        pace <= 2'h2;
        repeat (100) @(posedge ref_clk);
        @(negedge ref_clk);
        w = u_sink.got;
        chk("drained", 32'h0, out_valid);
        chk("drain_count", FIFO_DEPTH, w.size());
        for (int k = 1; k < w.size(); k++) begin
            chk("drain_order", w[k-1] + 16'h1, w[k]);
        end
    endtask

    // Restart ignored without permit, honoured with it; ramp then wraps.
    task automatic test_restart;
        logic [31:0] s0;
        logic [15:0] w[$];
        int          bad;
        bad = 0;
        pace = 2'h0;
        wr(IDX_SOURCE_SEL, {28'h0, SEL_RAMP});
        repeat (45) @(posedge ref_clk);
        ahb(1'b0, IDX_STATUS, 32'h0000_0000, s0);
        // Software pulses high then low, with zeros above the fields.
        wr(IDX_RESTART_CTL, 32'h0000_0002);
        wr(IDX_RESTART_CTL, 32'h0000_0000);
        rd_chk("no_permit", IDX_STATUS, s0);
        wr(IDX_RESTART_CTL, 32'h0000_0001);
        wr(IDX_RESTART_CTL, 32'h0000_0003);
        wr(IDX_RESTART_CTL, 32'h0000_0001);
        rd_chk("permit_rd", IDX_RESTART_CTL, 32'h0000_0001);
        rd_chk("restarted", IDX_STATUS, 32'h0000_0000);
        @(negedge ref_clk);
        u_sink.got.delete();
        pace = 2'h1;
        repeat (16500) @(posedge ref_clk);
        @(negedge ref_clk);
        w = u_sink.got;
        chk("ramp_len", 1, 32'(w.size() > 16452));
        for (int k = 0; k < 16420 && k + 32 < w.size(); k++) begin
            if (w[32+k] !== 16'(k % (RAMP_MAX + 1))) bad++;
        end
        chk("ramp_wrap", 32'h0, bad);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        test_registers();
        sample_valid <= 1'b1;
        for (int s = 0; s < 16; s++) begin
            check_mode(4'(s));
        end
        test_fill_drain();
        test_restart();
        tally_and_finish();
    end

    // The whole run needs about eighteen thousand cycles.
    initial begin
        #(50 * 30000);
        fail_count++;
        $display("MISMATCH watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
